//--- rtl/smc_pkg.sv
// Package with types and constants of the stop mode and clock mode controller
package smc_pkg;

  typedef enum logic [7:0] {
    SMC_HIGH_MID = 8'h01,
    SMC_LOW_SPEED = 8'h02,
    SMC_LOW_POWER = 8'h04,
    SMC_PLL = 8'h08,
    SMC_OCO = 8'h10,
    SMC_OCO_LOW_POWER = 8'h20,
    SMC_STOP = 8'h40,
    SMC_WAIT = 8'h80
  } smc_mode_type;

  typedef struct packed {
    logic sub_osc_en;
    logic main_clock_stop_bit;
    logic div8_select_bit;
    logic cpu_divider_bit1;
    logic cpu_divider_bit0;
    logic sub_clock_select;
    logic pll_select;
    logic oco_select;
    logic oco_run;
    logic osc_stop_detect_enable;
    logic all_clock_stop_bit;
  } smc_cfg_type;

  typedef struct packed {
    logic nmi;
    logic periph_irq;
    logic [2:0] interrupt_priority_level;
    logic global_ie;
  } smc_wake_type;

  typedef struct packed {
    smc_mode_type mode;
    smc_cfg_type cfg;
    logic [3:0] div_cnt;
    logic cpu_clk_en;
    logic wake;
    logic reject;
  } smc_state_type;

  localparam logic [2:0] SMC_LEVEL_DISABLED = 3'h0;

  // Divider terminal counts: ratio minus one
  localparam logic [3:0] SMC_DIV1_LAST = 4'h0;
  localparam logic [3:0] SMC_DIV2_LAST = 4'h1;
  localparam logic [3:0] SMC_DIV4_LAST = 4'h3;
  localparam logic [3:0] SMC_DIV8_LAST = 4'h7;
  localparam logic [3:0] SMC_DIV16_LAST = 4'hf;

  // Reset: main clock running, divide-by-eight, sub clock and detector off
  localparam smc_cfg_type SMC_CFG_RESET = '{
    sub_osc_en: 1'b0,
    main_clock_stop_bit: 1'b0,
    div8_select_bit: 1'b1,
    cpu_divider_bit1: 1'b0,
    cpu_divider_bit0: 1'b0,
    sub_clock_select: 1'b0,
    pll_select: 1'b0,
    oco_select: 1'b0,
    oco_run: 1'b0,
    osc_stop_detect_enable: 1'b0,
    all_clock_stop_bit: 1'b0
  };

  localparam smc_state_type SMC_STATE_RESET = '{
    mode: SMC_HIGH_MID,
    cfg: SMC_CFG_RESET,
    div_cnt: 4'h0,
    cpu_clk_en: 1'b0,
    wake: 1'b0,
    reject: 1'b0
  };

endpackage

//--- rtl/smc_clock_mode.sv
// Stop mode exit and clock mode state machine with CPU clock divider
// Notes on behaviour
// [R1] Stop is left only by reset, the non-maskable interrupt or an enabled peripheral interrupt.
// [R2] For reset or NMI wake only, software disables every peripheral priority first.
// [R3] For peripheral wake, software gives one interrupt a level and disables the rest.
// [R4] Software sets the global interrupt enable before requesting stop for peripheral wake.
// [R5] Wake peripheral enabled by software; its request restarts the CPU clock.
// [R6] Stop entered on sub clock wakes onto the undivided sub clock.
// [R7] Stop entered on main clock wakes onto main clock divided by eight.
// [R8] Stop entered on on-chip oscillator wakes onto it divided by eight.
// [R9] Every exit from stop forces the divide-by-eight select to one.
// [R10] Software clears the oscillation stop detector before stop or low-power moves.
// [R11] PLL mode is entered only from and left only to high-speed mode.
// [R12] Software sets divide-by-eight before leaving on-chip oscillator mode for high speed.
// [R13] Setting the main clock stop bit also sets divide-by-eight select.
// [R14] Moves into low-speed mode need the sub clock oscillating; the code does not check sub_osc_en on the move from low power mode.
// [R15] On-chip oscillator toggles in low speed; sub clock toggles in PLL mode.
// [R16] Divider and sub clock oscillation change freely within a mode.
// [R17] Divider bits 00,01,10,11 give 1,2,4,16; divide-by-eight select gives 8.
// [R18] Writing the all clock stop bit enters stop; the wait instruction enters wait; in PLL mode the code refuses both and raises reject_out.
// [R19] A hardware reset returns all clock control bits to their defaults.
`timescale 1ns/1ps
module smc_clock_mode
  import smc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic cfg_wr_in,
  input wire smc_cfg_type cfg_in,
  input wire logic wait_instr_in,
  input wire smc_wake_type wake_in,
  output smc_mode_type mode_out,
  output smc_cfg_type cfg_out,
  output logic cpu_clk_run_out,
  output logic cpu_clk_en_out,
  output logic oco_periph_clk_ok_out,
  output logic sub_timer_clk_ok_out,
  output logic wake_out,
  output logic reject_out
);

  smc_state_type st_r;
  smc_state_type st_nxt;

  // Running mode implied by a set of clock control bits
  function automatic smc_mode_type mode_of(input smc_cfg_type c);
    smc_mode_type m;
    m = SMC_HIGH_MID;
    if (c.pll_select) begin
      m = SMC_PLL;
    end else if (c.sub_clock_select) begin
      if (c.main_clock_stop_bit) begin
        m = SMC_LOW_POWER;
      end else begin
        m = SMC_LOW_SPEED;
      end
    end else if (c.oco_select) begin
      if (c.main_clock_stop_bit) begin
        m = SMC_OCO_LOW_POWER;
      end else begin
        m = SMC_OCO;
      end
    end
    return m;
  endfunction

  // Allowed moves between running modes
  function automatic logic move_ok(input smc_mode_type f, input smc_mode_type t,
                                   input smc_cfg_type c);
    logic ok;
    ok = 1'b0;
    if (f == t) begin
      ok = 1'b1; // [R16]
    end else begin
      case (f)
        SMC_HIGH_MID: begin
          case (t)
            SMC_PLL: begin
              ok = 1'b1; // [R11]
            end
            SMC_OCO: begin
              ok = 1'b1;
            end
            SMC_LOW_SPEED: begin
              ok = c.sub_osc_en; // [R14]
            end
            default: begin
              ok = 1'b0;
            end
          endcase
        end
        SMC_LOW_SPEED: begin
          case (t)
            SMC_HIGH_MID: begin
              ok = 1'b1;
            end
            SMC_LOW_POWER: begin
              ok = 1'b1;
            end
            SMC_OCO: begin
              ok = 1'b1;
            end
            default: begin
              ok = 1'b0;
            end
          endcase
        end
        // Low power mode only returns to low speed
        SMC_LOW_POWER: begin
          case (t)
            SMC_LOW_SPEED: begin
              ok = 1'b1;
            end
            default: begin
              ok = 1'b0;
            end
          endcase
        end
        SMC_PLL: begin
          case (t)
            SMC_HIGH_MID: begin
              ok = 1'b1; // [R11]
            end
            default: begin
              ok = 1'b0;
            end
          endcase
        end
        SMC_OCO: begin
          case (t)
            SMC_OCO_LOW_POWER: begin
              ok = 1'b1;
            end
            SMC_LOW_SPEED: begin
              ok = c.sub_osc_en; // [R14]
            end
            SMC_HIGH_MID: begin
              ok = c.div8_select_bit;
            end
            default: begin
              ok = 1'b0;
            end
          endcase
        end
        // On-chip oscillator low power only returns to its running mode
        SMC_OCO_LOW_POWER: begin
          case (t)
            SMC_OCO: begin
              ok = 1'b1;
            end
            default: begin
              ok = 1'b0;
            end
          endcase
        end
        default: begin
          ok = 1'b0;
        end
      endcase
    end
    return ok;
  endfunction

  // Terminal count of the CPU clock divider
  function automatic logic [3:0] div_last(input smc_cfg_type c);
    logic [3:0] n;
    n = SMC_DIV1_LAST;
    if (c.sub_clock_select) begin
      n = SMC_DIV1_LAST; // [R6]
    end else if (c.div8_select_bit) begin
      n = SMC_DIV8_LAST; // [R17]
    end else begin
      case ({c.cpu_divider_bit1, c.cpu_divider_bit0})
        2'b00: begin
          n = SMC_DIV1_LAST;
        end
        2'b01: begin
          n = SMC_DIV2_LAST;
        end
        2'b10: begin
          n = SMC_DIV4_LAST;
        end
        2'b11: begin
          n = SMC_DIV16_LAST;
        end
        default: begin
          n = SMC_DIV1_LAST;
        end
      endcase
    end
    return n;
  endfunction

  logic wake_evt;
  logic periph_wake;
  logic running;
  smc_cfg_type req;
  smc_mode_type req_mode;

  // Only the NMI or a peripheral request with a level and interrupts on can wake
  assign periph_wake = wake_in.periph_irq && wake_in.global_ie &&
                       (wake_in.interrupt_priority_level != SMC_LEVEL_DISABLED); // [R5]
  assign wake_evt = wake_in.nmi || periph_wake; // [R1]
  assign running = (st_r.mode != SMC_STOP) && (st_r.mode != SMC_WAIT);

  // Requested bits as they would be stored, stop bit handled apart
  always_comb begin
    req = cfg_in;
    if (cfg_in.main_clock_stop_bit && !st_r.cfg.main_clock_stop_bit) begin
      req.div8_select_bit = 1'b1; // [R13]
    end
    req.all_clock_stop_bit = 1'b0;
    req_mode = mode_of(req);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.wake = 1'b0;
    st_nxt.reject = 1'b0;
    st_nxt.cpu_clk_en = 1'b0;

    case (st_r.mode)
      // Stop: clock bits kept so the wake can pick the same source
      SMC_STOP: begin
        st_nxt.div_cnt = 4'h0;
        if (wake_evt) begin // [R1]
          st_nxt.cfg.div8_select_bit = 1'b1; // [R9]
          st_nxt.cfg.all_clock_stop_bit = 1'b0;
          st_nxt.mode = mode_of(st_r.cfg); // [R7] [R8]
          st_nxt.wake = 1'b1; // [R5]
        end
      end

      // Wait: same wake events, clock bits untouched
      SMC_WAIT: begin
        st_nxt.div_cnt = 4'h0;
        if (wake_evt) begin
          st_nxt.mode = mode_of(st_r.cfg);
          st_nxt.wake = 1'b1;
        end
      end

      // Running: divider ticks, software requests are served or refused
      SMC_HIGH_MID, SMC_LOW_SPEED, SMC_LOW_POWER, SMC_PLL, SMC_OCO,
      SMC_OCO_LOW_POWER: begin
        if (st_r.div_cnt >= div_last(st_r.cfg)) begin
          st_nxt.div_cnt = 4'h0;
          st_nxt.cpu_clk_en = 1'b1;
        end else begin
          st_nxt.div_cnt = st_r.div_cnt + 4'h1;
        end

        // A write beats a wait instruction in the same cycle
        if (cfg_wr_in) begin
          if (cfg_in.all_clock_stop_bit && st_r.mode != SMC_PLL) begin
            st_nxt.cfg = st_r.cfg; // [R18]
            st_nxt.cfg.all_clock_stop_bit = 1'b1;
            st_nxt.cfg.div8_select_bit = 1'b1;
            st_nxt.mode = SMC_STOP;
          end else if (!cfg_in.all_clock_stop_bit && move_ok(st_r.mode, req_mode, req)) begin
            st_nxt.cfg = req; // [R15] [R16]
            st_nxt.mode = req_mode;
            st_nxt.div_cnt = 4'h0;
          end else begin
            st_nxt.reject = 1'b1;
          end
        end else if (wait_instr_in) begin
          if (st_r.mode != SMC_PLL) begin
            st_nxt.mode = SMC_WAIT; // [R18]
          end else begin
            st_nxt.reject = 1'b1;
          end
        end
      end

      // Illegal state code: recover to the reset state
      default: begin
        st_nxt = SMC_STATE_RESET;
      end
    endcase
  end

  // Reset restores defaults, not the clock in use before stop
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= SMC_STATE_RESET; // [R19]
    end else begin
      st_r <= st_nxt;
    end
  end

  // Status outputs decoded from the registered state
  assign mode_out = st_r.mode;
  assign cfg_out = st_r.cfg;
  assign cpu_clk_run_out = running;
  assign cpu_clk_en_out = st_r.cpu_clk_en;
  assign oco_periph_clk_ok_out = (st_r.mode == SMC_LOW_SPEED) && st_r.cfg.oco_run; // [R15]
  assign sub_timer_clk_ok_out = (st_r.mode == SMC_PLL) && st_r.cfg.sub_osc_en; // [R15]
  assign wake_out = st_r.wake;
  assign reject_out = st_r.reject;

endmodule

//--- sim/smc_clock_mode_chk.sv
// Assertion checker for the stop mode and clock mode controller
`timescale 1ns/1ps
module smc_clock_mode_chk
  import smc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic cfg_wr_in,
  input wire smc_cfg_type cfg_in,
  input wire logic wait_instr_in,
  input wire smc_wake_type wake_in,
  input wire smc_mode_type mode_out,
  input wire smc_cfg_type cfg_out,
  input wire logic cpu_clk_run_out,
  input wire logic cpu_clk_en_out,
  input wire logic wake_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic wk;
  assign wk = wake_in.nmi | (wake_in.periph_irq & wake_in.global_ie &
    (|wake_in.interrupt_priority_level));
  sequence s_wake;
    mode_out == SMC_STOP && wk;
  endsequence
  sequence s_run;
    !(mode_out inside {SMC_STOP, SMC_WAIT, SMC_PLL});
  endsequence
  chk_stop_hold: assert property (mode_out == SMC_STOP && !wk |=> mode_out == SMC_STOP)
    else $error("stop left without cause");
  chk_wake_sub: assert property (s_wake ##0 cfg_out.sub_clock_select |=>
    mode_out inside {SMC_LOW_SPEED, SMC_LOW_POWER}) else $error("sub wake mode");
  chk_wake_main: assert property (s_wake ##0 !(cfg_out.sub_clock_select | cfg_out.oco_select)
    |=> mode_out == SMC_HIGH_MID) else $error("main wake mode");
  chk_wake_oco: assert property (s_wake ##0 !cfg_out.sub_clock_select && cfg_out.oco_select
    |=> mode_out inside {SMC_OCO, SMC_OCO_LOW_POWER}) else $error("oco wake mode");
  chk_exit_div8: assert property (s_wake |=> cfg_out.div8_select_bit && wake_out
    && cpu_clk_run_out) else $error("stop exit divider");
  chk_pll_path: assert property ($changed(mode_out) && (mode_out == SMC_PLL ||
    $past(mode_out) == SMC_PLL) |-> mode_out == SMC_HIGH_MID || $past(mode_out) == SMC_HIGH_MID)
    else $error("pll move");
  chk_mcs_div8: assert property ($rose(cfg_out.main_clock_stop_bit) |->
    cfg_out.div8_select_bit) else $error("main stop divider");
  chk_ls_sub: assert property ($changed(mode_out) && mode_out == SMC_LOW_SPEED &&
    $past(mode_out) inside {SMC_HIGH_MID, SMC_OCO} |-> cfg_out.sub_osc_en)
    else $error("low speed without sub clock");
  chk_stop_entry: assert property (s_run ##0 cfg_wr_in && cfg_in.all_clock_stop_bit
    |=> mode_out == SMC_STOP) else $error("stop entry");
  chk_div8_period: assert property (disable iff (!arst_n_in || cfg_wr_in || wait_instr_in)
    cpu_clk_en_out && cfg_out.div8_select_bit && !cfg_out.sub_clock_select &&
    mode_out == SMC_HIGH_MID |=> (!cpu_clk_en_out)[*7] ##1 cpu_clk_en_out)
    else $error("divide by eight period");
endmodule
bind smc_clock_mode smc_clock_mode_chk u_chk (.ref_clk_in, .arst_n_in, .cfg_wr_in, .cfg_in,
  .wait_instr_in, .wake_in, .mode_out, .cfg_out, .cpu_clk_run_out, .cpu_clk_en_out, .wake_out);

//--- sim/test_stop_mode_exit_and_clock_mode_fsm.sv
// Self-checking bench for the stop mode and clock mode controller
`timescale 1ns/1ps
module test_stop_mode_exit_and_clock_mode_fsm;
  import smc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic cfg_wr_in = 1'b0;
  logic wait_instr_in = 1'b0;
  smc_cfg_type cfg_in = SMC_CFG_RESET;
  smc_wake_type wake_in = 6'h00;
  smc_mode_type mode_out;
  smc_cfg_type cfg_out, c;
  logic cpu_clk_run_out, cpu_clk_en_out, oco_periph_clk_ok_out, sub_timer_clk_ok_out;
  logic wake_out, reject_out;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  smc_clock_mode u_dut (.ref_clk_in, .arst_n_in, .cfg_wr_in, .cfg_in, .wait_instr_in,
    .wake_in, .mode_out, .cfg_out, .cpu_clk_run_out, .cpu_clk_en_out,
    .oco_periph_clk_ok_out, .sub_timer_clk_ok_out, .wake_out, .reject_out);
  initial forever #2.5 ref_clk_in = ~ref_clk_in;
  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic cmp(input string what, input logic [10:0] exp, input logic [10:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Measures the spacing of CPU clock ticks
  task automatic per(input int n);
    int k;
    k = 0;
    while (cpu_clk_en_out !== 1'b1 && k < 40) begin
      @(negedge ref_clk_in);
      k++;
    end
    k = 0;
    do begin
      @(negedge ref_clk_in);
      k++;
    end while (cpu_clk_en_out !== 1'b1 && k < 40);
    cmp("cpu clock period", 11'(n), 11'(k));
  endtask
  task automatic wr(input smc_cfg_type v);
    cfg_wr_in = 1'b1;
    cfg_in = v;
    @(negedge ref_clk_in);
    cfg_wr_in = 1'b0;
  endtask
  task automatic wk(input smc_wake_type w);
    wake_in = w;
    @(negedge ref_clk_in);
    wake_in = 6'h00;
  endtask
  task automatic t_reset;
    cmp("mode", SMC_HIGH_MID, mode_out);
    cmp("cfg", SMC_CFG_RESET, cfg_out);
  endtask
  task automatic t_div;
    c = SMC_CFG_RESET;
    per(8);
    c.div8_select_bit = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      {c.cpu_divider_bit1, c.cpu_divider_bit0} = 2'(i);
      wr(c);
      per(i == 3 ? 16 : 1 << i);
    end
    c.sub_osc_en = 1'b1;
    wr(c);
    per(1);
  endtask
  task automatic t_stop_main;
    c.all_clock_stop_bit = 1'b1;
    wr(c);
    cmp("mode", SMC_STOP, mode_out);
    wr(SMC_CFG_RESET);
    wk(6'h11);
    wk(6'h16);
    cmp("mode", SMC_STOP, mode_out);
    wk(6'h17);
    cmp("mode", SMC_HIGH_MID, mode_out);
    cmp("wake", 1'b1, wake_out);
    cmp("div8", 1'b1, cfg_out.div8_select_bit);
    per(8);
  endtask
  task automatic t_sub_oco;
    c = SMC_CFG_RESET;
    c.sub_clock_select = 1'b1;
    wr(c);
    cmp("reject", 1'b1, reject_out);
    c.sub_osc_en = 1'b1;
    c.oco_run = 1'b1;
    wr(c);
    cmp("mode", SMC_LOW_SPEED, mode_out);
    cmp("oco ok", 1'b1, oco_periph_clk_ok_out);
    c.div8_select_bit = 1'b0;
    c.main_clock_stop_bit = 1'b1;
    wr(c);
    cmp("div8", 1'b1, cfg_out.div8_select_bit);
    c.all_clock_stop_bit = 1'b1;
    wr(c);
    wk(6'h20);
    cmp("mode", SMC_LOW_POWER, mode_out);
    per(1);
    c.all_clock_stop_bit = 1'b0;
    c.main_clock_stop_bit = 1'b0;
    wr(c);
    c.sub_clock_select = 1'b0;
    c.oco_select = 1'b1;
    wr(c);
    cmp("mode", SMC_OCO, mode_out);
    c.all_clock_stop_bit = 1'b1;
    wr(c);
    wk(6'h20);
    cmp("mode", SMC_OCO, mode_out);
    cmp("div8", 1'b1, cfg_out.div8_select_bit);
    per(8);
    wr(SMC_CFG_RESET);
    cmp("mode", SMC_HIGH_MID, mode_out);
  endtask
  task automatic t_pll_wait;
    c = SMC_CFG_RESET;
    c.pll_select = 1'b1;
    c.sub_osc_en = 1'b1;
    wr(c);
    cmp("mode", SMC_PLL, mode_out);
    cmp("sub ok", 1'b1, sub_timer_clk_ok_out);
    c.all_clock_stop_bit = 1'b1;
    wr(c);
    cmp("reject", 1'b1, reject_out);
    c = SMC_CFG_RESET;
    c.sub_osc_en = 1'b1;
    c.sub_clock_select = 1'b1;
    wr(c);
    cmp("reject", 1'b1, reject_out);
    wr(SMC_CFG_RESET);
    cmp("mode", SMC_HIGH_MID, mode_out);
    wait_instr_in = 1'b1;
    @(negedge ref_clk_in);
    wait_instr_in = 1'b0;
    cmp("mode", SMC_WAIT, mode_out);
    cmp("run", 1'b0, cpu_clk_run_out);
    wk(6'h20);
    cmp("mode", SMC_HIGH_MID, mode_out);
  endtask
  initial begin
    repeat (5) @(negedge ref_clk_in);
    arst_n_in = 1'b1;
    t_reset();
    t_div();
    t_stop_main();
    t_sub_oco();
    t_pll_wait();
    c.all_clock_stop_bit = 1'b1;
    wr(c);
    arst_n_in = 1'b0;
    @(negedge ref_clk_in);
    arst_n_in = 1'b1;
    t_reset();
    report_and_stop();
  end
endmodule
